// File: hdl/slq_cfg_reg.sv
`timescale 1ns/10ps
module slq_cfg_reg
  import slq_pkg::*;
#(
  parameter slq_pkg::slq_data_t MASK = 8'hff,
  parameter slq_pkg::slq_data_t RST = 8'h00
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire slq_pkg::slq_data_t wdata,
  input wire logic load_en,
  input wire slq_pkg::slq_data_t load_val,
  output slq_pkg::slq_data_t q
);

  typedef struct packed {
    slq_data_t val;
  } slq_cfg_s;

  slq_cfg_s st_r;
  slq_cfg_s st_nxt;
  slq_data_t merged;

  // ----------------------------------------------------------------
  // per-bit merge: preset bits in field, old bits outside
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < DATA_W; b++)
    begin : g_bit
      assign merged[b] = MASK[b] ? load_val[b] : st_r.val[b];
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    if (load_en)
    begin
      st_nxt.val = merged;
    end
    else if (wr_en)
    begin
      st_nxt.val = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r.val <= RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.val;

endmodule

// File: hdl/slq_preset_rom.sv
`timescale 1ns/10ps
module slq_preset_rom
  import slq_pkg::*;
(
  input wire slq_pkg::slq_data_t code,
  output slq_pkg::slq_preset_s preset
);

  // ----------------------------------------------------------------
  // code decode, pure lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    case (code)
      CODE_TWO_LANE: preset = PRE_TWO_LANE;
      CODE_FOUR_LANE: preset = PRE_FOUR_LANE;
      CODE_SIX_LANE: preset = PRE_SIX_LANE;
      CODE_EIGHT_LANE: preset = PRE_EIGHT_LANE;
      CODE_DBL_EIGHT: preset = PRE_DBL_EIGHT;
      CODE_HBW1_L1: preset = PRE_HBW1_L1;
      CODE_HBW1_L2: preset = PRE_HBW1_L2;
      CODE_LBW1_L1: preset = PRE_LBW1_L1;
      CODE_HBW2_L1: preset = PRE_HBW2_L1;
      // reserved and unknown codes load nothing
      default: preset = PRE_NONE;
    endcase
  end

endmodule

// File: hdl/slq_quick_setup.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
// Summary of operation
// - quick-setup register clears itself after every write; nothing is held.
// - reading the quick-setup register always returns zero.
// - quick-setup steers nothing itself; it loads preset fields into link config registers and records the code, a count and an applied pulse.
// - code 0x02 loads 0x0, 0x1, 0xB, 0xF into the four fields.
// - code 0x04 loads 0x0, 0x3, 0xB, 0xF into the four fields.
// - code 0x06 loads 0x0, 0x5, 0xB, 0xB into the four fields.
// - code 0x08 loads 0x0, 0x7, 0xB, 0xF into the four fields.
// - code 0x48 loads 0x4, 0x7, 0xF, 0xF into the four fields.
// - code 0x81 loads 0x8, 0x0, 0xF, 0xF into the four fields.
// - code 0x82 loads 0x8, 0x1, 0xF, 0xF into the four fields.
// - code 0x91 loads 0x9, 0x0, 0xF, 0xF into the four fields.
// - code 0xC1 loads 0xC, 0x0, 0xF, 0xF into the four fields.
// - any unlisted or reserved code leaves all link registers unchanged.
module slq_quick_setup
  import slq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire slq_pkg::slq_bus_s bus,
  output slq_pkg::slq_data_t rdata,
  output slq_pkg::slq_bank_t cfg,
  output logic preset_applied
);

  typedef struct packed {
    slq_data_t rdata;
    logic applied;
    slq_data_t last_code;
    slq_data_t apply_cnt;
  } slq_top_s;

  slq_top_s st_r;
  slq_top_s st_nxt;
  slq_preset_s preset;
  slq_bank_t cfg_q;
  logic quick_wr;
  logic quick_load;
  logic [NUM_TGT-1:0] tgt_wr;
  logic [NUM_TGT-1:0] tgt_sel;

  // ----------------------------------------------------------------
  // preset decode
  // ----------------------------------------------------------------
  // decode is combinational so the load lands on the accepting edge
  slq_preset_rom u_rom (
    .code (bus.wdata),
    .preset (preset)
  );

  // the code is only decoded, so a read of it can only see zero
  // write is consumed, not held at ADDR_QUICK; only last_code keeps a code that hits
  assign quick_wr = bus.wr && (bus.addr == ADDR_QUICK);
  assign quick_load = quick_wr && preset.hit;

  // ----------------------------------------------------------------
  // link configuration registers
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_TGT; i++)
    begin : g_tgt
      // a preset and a direct write never meet: different addresses
      assign tgt_sel[i] = (bus.addr == TGT_ADDR[i]);
      // direct writes land after the preset that preceded them
      assign tgt_wr[i] = bus.wr && tgt_sel[i];
      slq_cfg_reg #(
        .MASK (TGT_MASK[i]),
        .RST (TGT_RST[i])
      ) u_cfg (
        .ref_clk (ref_clk),
        .rstn (rstn),
        .wr_en (tgt_wr[i]),
        .wdata (bus.wdata),
        .load_en (quick_load),
        .load_val (preset.val[i]),
        .q (cfg_q[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux and status
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // pulse lasts one cycle; software never has to clear it
    st_nxt.applied = quick_load;
    if (quick_load)
    begin
      st_nxt.last_code = bus.wdata;
      st_nxt.apply_cnt = st_r.apply_cnt + CNT_STEP;
    end
    if (bus.rd)
    begin
      st_nxt.rdata = READ_UNMAPPED;
      case (bus.addr)
        ADDR_QUICK: st_nxt.rdata = QUICK_READ;
        ADDR_LAST_CODE: st_nxt.rdata = st_r.last_code;
        ADDR_APPLY_CNT: st_nxt.rdata = st_r.apply_cnt;
        default:
        begin
          for (int k = 0; k < NUM_TGT; k++)
          begin
            if (tgt_sel[k])
            begin
              st_nxt.rdata = cfg_q[k];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r.rdata <= READ_UNMAPPED;
      st_r.applied <= 1'b0;
      st_r.last_code <= LAST_CODE_RST;
      st_r.apply_cnt <= CNT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  // the link registers and the applied pulse leave the block; last code and count only by read
  assign cfg = cfg_q;
  assign preset_applied = st_r.applied;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // field bits only; outside bits are the business of f_keep
  function automatic logic f_match(input slq_bank_t bank, input slq_preset_s p);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < NUM_TGT; k++)
    begin
      ok = ok && ((bank[k] & TGT_MASK[k]) == p.val[k]);
    end
    return ok;
  endfunction

  function automatic logic f_keep(input slq_bank_t now_b, input slq_bank_t old_b);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < NUM_TGT; k++)
    begin
      ok = ok && ((now_b[k] & ~TGT_MASK[k]) == (old_b[k] & ~TGT_MASK[k]));
    end
    return ok;
  endfunction

  // one clock domain, so one default clocking for the checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_self_clear;
    quick_wr ##1 (bus.rd && bus.addr == ADDR_QUICK) |=> (rdata == QUICK_READ);
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("quick-setup value survived its write");

  property p_read_zero;
    (bus.rd && bus.addr == ADDR_QUICK) |=> (rdata == QUICK_READ);
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("quick-setup read not zero");

  property p_no_side_path;
    !bus.wr |=> $stable(cfg);
  endproperty
  a_no_side_path: assert property (p_no_side_path)
    else $error("link registers changed without a write");

  property p_two_lane;
    (quick_wr && bus.wdata == CODE_TWO_LANE) |=> f_match(cfg, PRE_TWO_LANE);
  endproperty
  a_two_lane: assert property (p_two_lane)
    else $error("two-lane preset fields wrong");

  property p_four_lane;
    (quick_wr && bus.wdata == CODE_FOUR_LANE) |=> f_match(cfg, PRE_FOUR_LANE);
  endproperty
  a_four_lane: assert property (p_four_lane)
    else $error("four-lane preset fields wrong");

  property p_six_lane;
    (quick_wr && bus.wdata == CODE_SIX_LANE) |=> f_match(cfg, PRE_SIX_LANE);
  endproperty
  a_six_lane: assert property (p_six_lane)
    else $error("six-lane preset fields wrong");

  property p_eight_lane;
    (quick_wr && bus.wdata == CODE_EIGHT_LANE) |=> f_match(cfg, PRE_EIGHT_LANE);
  endproperty
  a_eight_lane: assert property (p_eight_lane)
    else $error("eight-lane preset fields wrong");

  property p_dbl_eight;
    (quick_wr && bus.wdata == CODE_DBL_EIGHT) |=> f_match(cfg, PRE_DBL_EIGHT);
  endproperty
  a_dbl_eight: assert property (p_dbl_eight)
    else $error("doubled-rate preset fields wrong");

  property p_hbw1_l1;
    (quick_wr && bus.wdata == CODE_HBW1_L1) |=> f_match(cfg, PRE_HBW1_L1);
  endproperty
  a_hbw1_l1: assert property (p_hbw1_l1)
    else $error("one high-bw one-lane preset fields wrong");

  property p_hbw1_l2;
    (quick_wr && bus.wdata == CODE_HBW1_L2) |=> f_match(cfg, PRE_HBW1_L2);
  endproperty
  a_hbw1_l2: assert property (p_hbw1_l2)
    else $error("one high-bw two-lane preset fields wrong");

  property p_lbw1_l1;
    (quick_wr && bus.wdata == CODE_LBW1_L1) |=> f_match(cfg, PRE_LBW1_L1);
  endproperty
  a_lbw1_l1: assert property (p_lbw1_l1)
    else $error("one low-bw one-lane preset fields wrong");

  property p_hbw2_l1;
    (quick_wr && bus.wdata == CODE_HBW2_L1) |=> f_match(cfg, PRE_HBW2_L1);
  endproperty
  a_hbw2_l1: assert property (p_hbw2_l1)
    else $error("two high-bw one-lane preset fields wrong");

  property p_unknown_code;
    (quick_wr && !preset.hit) |=> ($stable(cfg) && !preset_applied);
  endproperty
  a_unknown_code: assert property (p_unknown_code)
    else $error("unlisted code changed link registers");

  property p_same_edge;
    quick_load |=> (preset_applied && (st_r.last_code == $past(bus.wdata))
                    && f_match(cfg, $past(preset)));
  endproperty
  a_same_edge: assert property (p_same_edge)
    else $error("preset not applied on the accepting edge");

  property p_keep_outside;
    quick_wr |=> f_keep(cfg, $past(cfg));
  endproperty
  a_keep_outside: assert property (p_keep_outside)
    else $error("bits outside preset fields changed");

  property p_applied_cause;
    preset_applied |-> $past(quick_load);
  endproperty
  a_applied_cause: assert property (p_applied_cause)
    else $error("applied flag without a preset write");

  // ----------------------------------------------------------------
  // read port and status checks
  // ----------------------------------------------------------------
  property p_read_hold;
    !bus.rd |=> $stable(rdata);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data moved without a read");

  property p_unmapped_read;
    (bus.rd && (tgt_sel == '0) && (bus.addr != ADDR_QUICK)
      && (bus.addr != ADDR_LAST_CODE) && (bus.addr != ADDR_APPLY_CNT))
      |=> (rdata == READ_UNMAPPED);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_last_code_read;
    (bus.rd && bus.addr == ADDR_LAST_CODE) |=> (rdata == $past(st_r.last_code));
  endproperty
  a_last_code_read: assert property (p_last_code_read)
    else $error("last preset code read back wrong");

  property p_count_read;
    (bus.rd && bus.addr == ADDR_APPLY_CNT) |=> (rdata == $past(st_r.apply_cnt));
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("preset count read back wrong");

  property p_count_step;
    quick_load |=> (st_r.apply_cnt == $past(st_r.apply_cnt) + CNT_STEP);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("preset count did not step");

  property p_status_hold;
    !quick_load |=> ($stable(st_r.last_code) && $stable(st_r.apply_cnt));
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status moved without a preset");

  // ----------------------------------------------------------------
  // per-target access checks
  // ----------------------------------------------------------------
  genvar j;
  generate
    for (j = 0; j < NUM_TGT; j++)
    begin : g_chk
      // a later direct write lands whole
      property p_direct_write;
        @(posedge ref_clk) disable iff (!rstn)
          tgt_wr[j] |=> (cfg[j] == $past(bus.wdata));
      endproperty
      a_direct_write: assert property (p_direct_write)
        else $error("direct link register write lost");

      property p_read_tgt;
        @(posedge ref_clk) disable iff (!rstn)
          (bus.rd && tgt_sel[j]) |=> (rdata == $past(cfg[j]));
      endproperty
      a_read_tgt: assert property (p_read_tgt)
        else $error("link register read back wrong");
    end
  endgenerate

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  c_two_lane: cover property (quick_wr && bus.wdata == CODE_TWO_LANE);
  c_reserved: cover property (quick_wr && !preset.hit);
  c_read_back: cover property (quick_wr ##1 (bus.rd && bus.addr == ADDR_QUICK));
  c_edit_after: cover property (quick_load ##[1:4] (tgt_wr != '0));
  c_status_read: cover property (bus.rd && bus.addr == ADDR_APPLY_CNT);

endmodule

// File: pkg/slq_pkg.sv
package slq_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_TGT = 4;

  typedef logic [ADDR_W-1:0] slq_addr_t;
  typedef logic [DATA_W-1:0] slq_data_t;
  typedef logic [NUM_TGT-1:0][DATA_W-1:0] slq_bank_t;

  typedef struct packed {
    logic wr;
    logic rd;
    slq_addr_t addr;
    slq_data_t wdata;
  } slq_bus_s;

  // val[0]..val[3] follow the order of TGT_ADDR
  typedef struct packed {
    logic hit;
    slq_bank_t val;
  } slq_preset_s;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam slq_addr_t ADDR_QUICK = 12'h05e;
  localparam slq_addr_t ADDR_LAST_CODE = 12'h0f0;
  localparam slq_addr_t ADDR_APPLY_CNT = 12'h0f1;
  localparam logic [NUM_TGT-1:0][ADDR_W-1:0] TGT_ADDR = {12'h073, 12'h072, 12'h06e, 12'h063};
  localparam slq_bank_t TGT_MASK = {8'h1f, 8'h1f, 8'h1f, 8'h0f};
  localparam slq_bank_t TGT_RST = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam slq_data_t QUICK_READ = 8'h00;
  localparam slq_data_t READ_UNMAPPED = 8'h00;
  localparam slq_data_t LAST_CODE_RST = 8'h00;
  localparam slq_data_t CNT_RST = 8'h00;
  localparam slq_data_t CNT_STEP = 8'h01;

  // ----------------------------------------------------------------
  // preset codes and their field values
  // ----------------------------------------------------------------
  localparam slq_data_t CODE_TWO_LANE = 8'h02;
  localparam slq_data_t CODE_FOUR_LANE = 8'h04;
  localparam slq_data_t CODE_SIX_LANE = 8'h06;
  localparam slq_data_t CODE_EIGHT_LANE = 8'h08;
  localparam slq_data_t CODE_DBL_EIGHT = 8'h48;
  localparam slq_data_t CODE_HBW1_L1 = 8'h81;
  localparam slq_data_t CODE_HBW1_L2 = 8'h82;
  localparam slq_data_t CODE_LBW1_L1 = 8'h91;
  localparam slq_data_t CODE_HBW2_L1 = 8'hc1;

  localparam slq_preset_s PRE_NONE = '0;
  localparam slq_preset_s PRE_TWO_LANE = {1'b1, 8'h0f, 8'h0b, 8'h01, 8'h00};
  localparam slq_preset_s PRE_FOUR_LANE = {1'b1, 8'h0f, 8'h0b, 8'h03, 8'h00};
  localparam slq_preset_s PRE_SIX_LANE = {1'b1, 8'h0b, 8'h0b, 8'h05, 8'h00};
  localparam slq_preset_s PRE_EIGHT_LANE = {1'b1, 8'h0f, 8'h0b, 8'h07, 8'h00};
  localparam slq_preset_s PRE_DBL_EIGHT = {1'b1, 8'h0f, 8'h0f, 8'h07, 8'h04};
  localparam slq_preset_s PRE_HBW1_L1 = {1'b1, 8'h0f, 8'h0f, 8'h00, 8'h08};
  localparam slq_preset_s PRE_HBW1_L2 = {1'b1, 8'h0f, 8'h0f, 8'h01, 8'h08};
  localparam slq_preset_s PRE_LBW1_L1 = {1'b1, 8'h0f, 8'h0f, 8'h00, 8'h09};
  localparam slq_preset_s PRE_HBW2_L1 = {1'b1, 8'h0f, 8'h0f, 8'h00, 8'h0c};

endpackage

// File: verification/slq_quick_setup_tb.sv
`timescale 1ns/10ps
module slq_quick_setup_tb;
  import slq_pkg::*;
  logic ref_clk;
  logic rstn;
  slq_bus_s bus;
  slq_data_t rdata;
  slq_bank_t cfg;
  logic preset_applied;
  int err_count;
  int checks;
  slq_data_t ecfg [NUM_TGT];
  slq_data_t elast;
  slq_data_t ecnt;
  slq_data_t pcode [9];
  logic [15:0] pval [9];
  slq_data_t bad [7];

  slq_quick_setup slq_quick_setup_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bus(bus),
    .rdata(rdata),
    .cfg(cfg),
    .preset_applied(preset_applied)
  );

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input slq_data_t got, input slq_data_t exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input slq_addr_t a, input slq_data_t d);
    @(posedge ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd_chk(input slq_addr_t a, input slq_data_t exp);
    @(posedge ref_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, exp, "read data");
  endtask

  task automatic chk_bank(input bit by_read);
    for (int t = 0; t < NUM_TGT; t++)
    begin
      chk(cfg[t], ecfg[t], "config port");
      if (by_read)
        rd_chk(TGT_ADDR[t], ecfg[t]);
    end
  endtask

  // only field bits move; the rest keep their prior value
  task automatic apply_exp(input int i);
    ecfg[0] = (ecfg[0] & 8'hf0) | {4'h0, pval[i][15:12]};
    ecfg[1] = (ecfg[1] & 8'he0) | {4'h0, pval[i][11:8]};
    ecfg[2] = (ecfg[2] & 8'he0) | {4'h0, pval[i][7:4]};
    ecfg[3] = (ecfg[3] & 8'he0) | {4'h0, pval[i][3:0]};
    elast = pcode[i];
    ecnt = ecnt + 8'h01;
  endtask

  task automatic chk_status();
    rd_chk(ADDR_QUICK, 8'h00);
    rd_chk(ADDR_LAST_CODE, elast);
    rd_chk(ADDR_APPLY_CNT, ecnt);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("ERROR %0t: run timed out", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    bus = '0;
    rstn = 1'b0;
    err_count = 0;
    checks = 0;
    elast = 8'h00;
    ecnt = 8'h00;
    ecfg = '{default: 8'h00};
    // nibbles per code: 063, 06e, 072, 073
    pcode = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h48, 8'h81, 8'h82, 8'h91, 8'hc1};
    pval = '{16'h01bf, 16'h03bf, 16'h05bb, 16'h07bf, 16'h47ff, 16'h80ff, 16'h81ff, 16'h90ff,
      16'hc0ff};
    bad = '{8'h00, 8'h01, 8'h42, 8'h44, 8'h80, 8'h03, 8'hff};
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    chk_bit(preset_applied, 1'b0, "pulse after reset");
    chk_bank(1'b1);
    chk_status();
    rd_chk(12'h3ff, 8'h00);
    // every preset over dirty targets
    for (int i = 0; i < 9; i++)
    begin
      for (int t = 0; t < NUM_TGT; t++)
      begin
        ecfg[t] = i[0] ? 8'hff : 8'he4;
        wr_reg(TGT_ADDR[t], ecfg[t]);
      end
      wr_reg(ADDR_QUICK, pcode[i]);
      apply_exp(i);
      @(negedge ref_clk);
      chk_bit(preset_applied, 1'b1, "apply pulse");
      chk_bank(1'b0);
      @(negedge ref_clk);
      chk_bit(preset_applied, 1'b0, "pulse width");
      chk_bank(1'b1);
      chk_status();
    end
    // unlisted and reserved codes change nothing
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(ADDR_QUICK, bad[i]);
      @(negedge ref_clk);
      chk_bit(preset_applied, 1'b0, "no pulse");
      chk_bank(1'b0);
    end
    chk_status();
    // status registers are read only; unmapped write ignored
    wr_reg(ADDR_LAST_CODE, 8'h5a);
    wr_reg(ADDR_APPLY_CNT, 8'h5a);
    wr_reg(12'h3ff, 8'h5a);
    chk_status();
    chk_bank(1'b1);
    // read straight after a preset write
    @(posedge ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= ADDR_QUICK;
    bus.wdata <= pcode[0];
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, 8'h00, "read after preset");
    apply_exp(0);
    chk_bank(1'b0);
    // preset then edit, back to back
    @(posedge ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= ADDR_QUICK;
    bus.wdata <= 8'h48;
    @(posedge ref_clk);
    bus.addr <= TGT_ADDR[1];
    bus.wdata <= 8'h15;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, 8'h15, "edit after preset");
    apply_exp(4);
    ecfg[1] = 8'h15;
    chk_bank(1'b1);
    chk_status();
    // mid-run reset, released on a rising edge
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    ecfg = '{default: 8'h00};
    elast = 8'h00;
    ecnt = 8'h00;
    chk_bit(preset_applied, 1'b0, "pulse in reset");
    chk_bank(1'b0);
    @(posedge ref_clk);
    rstn <= 1'b1;
    chk_bank(1'b1);
    chk_status();
    // a preset after the post-release readback still lands
    wr_reg(ADDR_QUICK, pcode[7]);
    apply_exp(7);
    @(negedge ref_clk);
    chk_bit(preset_applied, 1'b1, "pulse after release");
    chk_bank(1'b1);
    chk_status();
    report_and_stop();
  end
endmodule
